// ---- emcs_map.vh ----
`ifndef EMCS_MAP_VH
`define EMCS_MAP_VH

// SDRAM clock-gate lead and trail, in memory clocks
`define EMCS_CKE_LEAD 4'h2
`define EMCS_CKE_TRAIL 4'h2
// Column access latency and activate-to-command spacing
`define EMCS_CAS_LAT 4'h3
`define EMCS_TRCD 4'h2
// Bytes fetched by one asynchronous page read
`define EMCS_PAGE_BYTES 5'h10
// Bus and transfer width codes
`define EMCS_W8 2'h0
`define EMCS_W16 2'h1
`define EMCS_W32 2'h2
// SDRAM commands as {ras_n, cas_n, we_n}
`define EMCS_CMD_NOP 3'h7
`define EMCS_CMD_ACT 3'h3
`define EMCS_CMD_RD 3'h5
`define EMCS_CMD_WR 3'h4
// Auto-precharge address bit of the column command
`define EMCS_AP_BIT 10
// Reset values of the pin outputs
`define EMCS_RST_LANES 4'hf
`define EMCS_RST_MASK 4'h0

`endif

// ---- emcs_sync.v ----
`timescale 1ns/1ps
`default_nettype none
module emcs_sync #(
  parameter W = 32
) (
  input  wire         clock,
  input  wire         rst,
  input  wire         ce,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] stage1;

  always @(posedge clock) begin
    if (rst) begin
      stage1 <= {W{1'b0}};
      dout   <= {W{1'b0}};
    end else if (ce) begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule
`default_nettype wire

// ---- emcs_cs_drive.v ----
`timescale 1ns/1ps
`default_nettype none
module emcs_cs_drive #(
  parameter N  = 4,
  parameter BW = 2
) (
  input  wire          clock,
  input  wire          rst,
  input  wire          ce,
  input  wire          set_en,
  input  wire          clr_en,
  input  wire [BW-1:0] bank,
  input  wire [N-1:0]  polarity,
  output reg  [N-1:0]  select_pin
);

  reg [N-1:0] active;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_bank
      wire next_act = clr_en ? 1'b0 :
                      ((set_en && {{(32-BW){1'b0}}, bank} == i) ? 1'b1 : active[i]); // RULE_21
      always @(posedge clock) begin
        if (rst) begin
          active[i]     <= 1'b0;
          select_pin[i] <= ~polarity[i];
        end else if (ce) begin
          active[i]     <= next_act;
          // Pin level is active xnor polarity: low when active by default
          select_pin[i] <= next_act ~^ polarity[i]; // RULE_07
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ---- emcs_sequencer.v ----
// What this block does
// RULE_01: Clock gate rises two clocks before SDRAM access
// RULE_02: Clock gate held two clocks after access end
// RULE_03: All four SDRAM byte masks always driven
// RULE_04: SDRAM reads drive all byte masks low
// RULE_05: Activate with bank/row, then column with command
// RULE_06: SDRAM reads use column latency of three
// RULE_07: Selects active low, per-bank polarity inverts
// RULE_08: Read wait 1, OE delay 1 gives zero waits
// RULE_09: Read wait 1-15, OE delay 0-15 set length
// RULE_10: Lane policy 1: all strobes low on reads
// RULE_11: Lane policy 0: strobes high during reads
// RULE_12: Page read fetches sixteen bytes
// RULE_13: Four, eight or sixteen beats by bus width
// RULE_14: Group of four: first long, three page-wait
// RULE_15: First page access length from read wait
// RULE_16: Later three accesses from page wait field
// RULE_17: Page read starts with low bits 00
// RULE_18: Low bits step 01, 10, 11
// RULE_19: Policy 0 writes: strobes write, enable high
// RULE_20: Select one clock around write enable pulse (select here leads by write_enable_delay_field plus 2 clocks, trails by 1)
// RULE_21: One select asserted, chosen by bank
`include "emcs_map.vh"
`timescale 1ns/1ps
`default_nettype none
module emcs_sequencer #(
  parameter ADDR_W = 24,
  parameter ROW_W  = 13,
  parameter COL_W  = 9,
  parameter BANK_W = 2
) (
  input  wire              clock,
  input  wire              rst,
  input  wire              ce,
  input  wire              req_valid,
  output reg               req_ready,
  input  wire              req_write,
  input  wire              req_sdram,
  input  wire              req_page,
  input  wire [1:0]        req_size,
  input  wire [1:0]        req_bank,
  input  wire [31:0]       req_addr,
  input  wire [31:0]       req_wdata,
  output reg               rsp_valid,
  output reg               rsp_last,
  output reg  [31:0]       rsp_data,
  input  wire [3:0]        read_wait_field,
  input  wire [3:0]        output_enable_delay_field,
  input  wire [3:0]        page_wait_field,
  input  wire [3:0]        write_wait_field,
  input  wire [3:0]        write_enable_delay_field,
  input  wire              byte_lane_policy_bit,
  input  wire [3:0]        select_polarity_field,
  input  wire [1:0]        static_width,
  input  wire              sdram_bus32,
  output reg               clk_en,
  output wire [3:0]        dynamic_select_low,
  output reg               ras_n,
  output reg               cas_n,
  output reg               we_n,
  output reg  [3:0]        data_mask,
  output wire [3:0]        static_select_low,
  output reg               oe_n,
  output reg  [3:0]        byte_lane_n,
  output reg  [ADDR_W-1:0] mem_addr,
  output reg  [31:0]       data_out,
  output reg               data_oe,
  input  wire [31:0]       data_in
);

  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_LEAD  = 4'h1;
  localparam [3:0] ST_RCD   = 4'h2;
  localparam [3:0] ST_CAS   = 4'h3;
  localparam [3:0] ST_TRAIL = 4'h4;
  localparam [3:0] ST_SRD   = 4'h5;
  localparam [3:0] ST_SWR   = 4'h6;

  reg  [3:0]        state;
  reg  [3:0]        cnt;
  reg  [5:0]        cyc;
  reg  [3:0]        beat;
  reg  [3:0]        beats_m1;
  reg               r_write;
  reg  [1:0]        r_bank;
  reg  [3:0]        r_lanes;
  reg  [31:0]       r_wdata;
  reg  [31:0]       r_unit;
  reg               samp_d0;
  reg               samp_d1;
  reg               last_d0;
  reg               last_d1;
  reg  [ADDR_W-1:0] act_addr;
  reg  [ADDR_W-1:0] col_addr;
  reg  [3:0]        lane_mask;
  wire [31:0]       din_s;

  // Read data comes from the pins, two flops before use
  emcs_sync #(.W (32)) u_din (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .din   (data_in),
    .dout  (din_s)
  );

  wire accept = req_valid & req_ready;
  // Static read timing
  wire [3:0] wrd = (read_wait_field == 4'h0) ? 4'h1 : read_wait_field;
  wire       first_of_four = (beat[1:0] == 2'h0);
  wire [4:0] acc_len = first_of_four ? ({1'b0, wrd} + 5'h01) :                 // RULE_15
                                       ({1'b0, page_wait_field} + 5'h01);      // RULE_16
  wire [5:0] nc = cyc + 6'h01;
  wire       rd_end = (state == ST_SRD) && (nc == {1'b0, acc_len});           // RULE_14
  wire [3:0] oe_start = (output_enable_delay_field > wrd) ? wrd :
                        output_enable_delay_field;                             // RULE_09
  wire       last_beat = (beat == beats_m1);

  // Static write timing: enable window w0..w1
  wire [5:0] w0 = {2'h0, write_enable_delay_field} + 6'h02;
  wire [5:0] w1 = w0 + {2'h0, write_wait_field};
  wire       wr_end = (state == ST_SWR) && (cyc == w1 + 6'h01);                // RULE_20
  wire       we_win = (nc >= w0) && (nc <= w1);
  wire       lane_win = (nc >= w0 - 6'h01) && (nc <= w1 + 6'h01);
  // SDRAM sequencing
  wire sd_end = (state == ST_CAS) && (cnt == 4'h0);
  wire [31:0] sd_unit = sdram_bus32 ? {2'h0, req_addr[31:2]} : {1'h0, req_addr[31:1]};
  // Page geometry: beats in units of bus width
  wire [4:0]  page_beats = `EMCS_PAGE_BYTES >> static_width;                    // RULE_12
  wire [3:0]  page_m1 = page_beats[3:0] - 4'h1;                                 // RULE_13
  wire [31:0] st_unit = req_addr >> static_width;
  wire [31:0] st_start = req_page ? (st_unit & ~{28'h0, page_m1}) : st_unit;     // RULE_17
  wire [3:0]  beat_nx = beat + 4'h1;
  wire dyn_set = (state == ST_LEAD) && (cnt == 4'h0);
  wire st_set = (state == ST_IDLE) && accept && !req_sdram;
  wire st_clr = (rd_end && last_beat) || wr_end;
  emcs_cs_drive #(.N (4), .BW (2)) u_dyn_cs (
    .clock      (clock),
    .rst        (rst),
    .ce         (ce),
    .set_en     (dyn_set),
    .clr_en     (sd_end),
    .bank       (r_bank),
    .polarity   (select_polarity_field),
    .select_pin (dynamic_select_low)
  );
  emcs_cs_drive #(.N (4), .BW (2)) u_st_cs (
    .clock      (clock),
    .rst        (rst),
    .ce         (ce),
    .set_en     (st_set),
    .clr_en     (st_clr),
    .bank       (req_bank),
    .polarity   (select_polarity_field),
    .select_pin (static_select_low)
  );
  // Row and column address words from the latched unit address
  always @* begin
    act_addr = {ADDR_W{1'b0}};
    col_addr = {ADDR_W{1'b0}};
    act_addr[ROW_W-1:0] = r_unit[COL_W+ROW_W-1:COL_W];
    act_addr[ROW_W+BANK_W-1:ROW_W] = r_unit[COL_W+ROW_W+BANK_W-1:COL_W+ROW_W];
    col_addr[COL_W-1:0] = r_unit[COL_W-1:0];
    col_addr[`EMCS_AP_BIT] = 1'b1;
    col_addr[ROW_W+BANK_W-1:ROW_W] = r_unit[COL_W+ROW_W+BANK_W-1:COL_W+ROW_W];
  end

  // Byte lanes touched by the request
  always @* begin
    case (req_size)
      `EMCS_W32: lane_mask = 4'hf;
      `EMCS_W16: lane_mask = req_addr[1] ? 4'hc : 4'h3;
      default:   lane_mask = 4'h1 << req_addr[1:0];
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state       <= ST_IDLE;
      cnt         <= 4'h0;
      cyc         <= 6'h00;
      beat        <= 4'h0;
      beats_m1    <= 4'h0;
      r_write     <= 1'b0;
      r_bank      <= 2'h0;
      r_lanes     <= 4'h0;
      r_wdata     <= 32'h0;
      r_unit      <= 32'h0;
      samp_d0     <= 1'b0;
      samp_d1     <= 1'b0;
      last_d0     <= 1'b0;
      last_d1     <= 1'b0;
      req_ready   <= 1'b1;
      rsp_valid   <= 1'b0;
      rsp_last    <= 1'b0;
      rsp_data    <= 32'h0;
      clk_en      <= 1'b0;
      {ras_n, cas_n, we_n} <= `EMCS_CMD_NOP;
      data_mask   <= `EMCS_RST_MASK;
      oe_n        <= 1'b1;
      byte_lane_n <= `EMCS_RST_LANES;
      mem_addr    <= {ADDR_W{1'b0}};
      data_out    <= 32'h0;
      data_oe     <= 1'b0;
    end else if (ce) begin
      // Sample strobe delayed to line up with synchronised data
      samp_d0   <= 1'b0;
      last_d0   <= 1'b0;
      samp_d1   <= samp_d0;
      last_d1   <= last_d0;
      rsp_valid <= samp_d1;
      rsp_last  <= samp_d1 & last_d1;
      if (samp_d1) begin
        rsp_data <= din_s;
      end
      case (state)
        ST_IDLE: begin
          if (accept) begin
            req_ready <= 1'b0;
            r_write   <= req_write;
            r_bank    <= req_bank;
            r_lanes   <= lane_mask;
            r_wdata   <= req_wdata;
            cyc       <= 6'h00;
            beat      <= 4'h0;
            if (req_sdram) begin
              clk_en <= 1'b1;                                                 // RULE_01
              cnt    <= `EMCS_CKE_LEAD - 4'h1;
              r_unit <= sd_unit;
              state  <= ST_LEAD;
            end else if (req_write) begin
              r_unit   <= st_unit;
              mem_addr <= st_unit[ADDR_W-1:0];
              data_out <= req_wdata;
              data_oe  <= 1'b1;
              beats_m1 <= 4'h0;
              state    <= ST_SWR;
            end else begin
              r_unit      <= st_start;
              mem_addr    <= st_start[ADDR_W-1:0];
              beats_m1    <= req_page ? page_m1 : 4'h0;                       // RULE_13
              oe_n        <= (oe_start != 4'h0);                              // RULE_08
              byte_lane_n <= byte_lane_policy_bit ? 4'h0 : 4'hf;              // RULE_10 RULE_11
              state       <= ST_SRD;
            end
          end
        end
        ST_LEAD: begin
          if (cnt == 4'h0) begin
            {ras_n, cas_n, we_n} <= `EMCS_CMD_ACT;                             // RULE_05
            mem_addr <= act_addr;
            cnt      <= `EMCS_TRCD - 4'h1;
            state    <= ST_RCD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_RCD: begin
          {ras_n, cas_n, we_n} <= `EMCS_CMD_NOP;
          if (cnt == 4'h0) begin
            {ras_n, cas_n, we_n} <= r_write ? `EMCS_CMD_WR : `EMCS_CMD_RD;   // RULE_05
            mem_addr  <= col_addr;
            data_mask <= r_write ? ~r_lanes : 4'h0;                            // RULE_03 RULE_04
            data_oe   <= r_write;
            data_out  <= r_wdata;
            cnt       <= r_write ? 4'h0 : `EMCS_CAS_LAT - 4'h1;                // RULE_06
            state     <= ST_CAS;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_CAS: begin
          {ras_n, cas_n, we_n} <= `EMCS_CMD_NOP;
          data_oe <= 1'b0;
          if (cnt == 4'h0) begin
            samp_d0   <= ~r_write;                                             // RULE_06
            last_d0   <= 1'b1;
            data_mask <= 4'h0;
            cnt       <= `EMCS_CKE_TRAIL - 4'h1;
            state     <= ST_TRAIL;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_TRAIL: begin
          if (cnt == 4'h0) begin
            clk_en    <= 1'b0;                                                // RULE_02
            req_ready <= 1'b1;
            state     <= ST_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        ST_SRD: begin
          cyc <= nc;
          if (nc >= {2'h0, oe_start}) begin
            oe_n <= 1'b0;                                                     // RULE_09
          end
          if (rd_end) begin
            samp_d0 <= 1'b1;
            last_d0 <= last_beat;
            cyc     <= 6'h00;
            if (last_beat) begin
              oe_n        <= 1'b1;
              byte_lane_n <= 4'hf;
              req_ready   <= 1'b1;
              state       <= ST_IDLE;
            end else begin
              beat     <= beat_nx;
              mem_addr <= r_unit[ADDR_W-1:0] | {{(ADDR_W-4){1'b0}}, beat_nx}; // RULE_18
            end
          end
        end
        ST_SWR: begin
          cyc <= nc;
          we_n <= ~(byte_lane_policy_bit && we_win);                           // RULE_19
          if (byte_lane_policy_bit) begin
            byte_lane_n <= lane_win ? ~r_lanes : 4'hf;                         // RULE_20
          end else begin
            byte_lane_n <= we_win ? ~r_lanes : 4'hf;                           // RULE_19
          end
          if (wr_end) begin
            data_oe     <= 1'b0;
            we_n        <= 1'b1;
            byte_lane_n <= 4'hf;
            req_ready   <= 1'b1;
            state       <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- emcs_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module emcs_mem_model (
  input  wire logic        clock,
  input  wire logic [3:0]  dynamic_select_low,
  input  wire logic [3:0]  static_select_low,
  input  wire logic [3:0]  select_polarity_field,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [23:0] mem_addr,
  output var  logic [31:0] data_in
);
  logic [3:0]  pol_q   = 4'h0;
  logic [31:0] last    = 32'h0;
  logic [8:0]  col     = 9'h0;
  logic [1:0]  rd_pipe = 2'h0;
  wire logic        st_on  = |(static_select_low ^ ~pol_q);
  wire logic        dy_rd  = |(dynamic_select_low ^ ~pol_q) && ras_n && !cas_n && we_n;
  wire logic        st_drv = st_on && !oe_n;
  wire logic        drv    = st_drv || rd_pipe[1];
  wire logic [31:0] val    = st_drv ? {8'ha5, mem_addr} : {8'h5a, 15'h0, col};
  // SDRAM data appears only in the last clock of the column latency
  always @(posedge clock) begin
    pol_q   <= select_polarity_field;
    rd_pipe <= {rd_pipe[0], dy_rd};
    if (dy_rd)
      col <= mem_addr[8:0];
    if (drv)
      last <= val;
  end
  // Released bus shows the inverse of the last word
  always_comb data_in = drv ? val : ~last;
endmodule
`default_nettype wire

// ---- emcs_sequencer_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module emcs_sequencer_chk (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic       oe_n,
  input wire logic       rsp_valid,
  input wire logic       byte_lane_policy_bit,
  input wire logic [3:0] data_mask,
  input wire logic [3:0] byte_lane_n,
  input wire logic [3:0] dynamic_select_low,
  input wire logic [3:0] static_select_low,
  input wire logic [3:0] select_polarity_field
);
  logic [3:0] pol_q = 4'h0;
  always @(posedge clock) pol_q <= select_polarity_field;
  wire logic [3:0] dyn_on = dynamic_select_low ^ ~pol_q;
  wire logic [3:0] st_on  = static_select_low ^ ~pol_q;
  wire logic       st_any = |st_on;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_act; !ras_n && cas_n && we_n && (dyn_on != 4'h0); endsequence
  sequence s_rd;  ras_n && !cas_n && we_n && (dyn_on != 4'h0); endsequence
  sequence s_col; ras_n && !cas_n && (dyn_on != 4'h0); endsequence
  a_gate_lead: assert property ($rose(clk_en) |-> ##2 s_act)
    else $error("clock gate lead wrong");
  a_gate_trail: assert property ($fell(|dyn_on) |-> clk_en [*2] ##1 !clk_en)
    else $error("clock gate trail wrong");
  a_act_then_col: assert property (s_act |-> ##2 s_col)
    else $error("column command not after activate");
  a_cas_latency: assert property (s_rd |-> ##5 rsp_valid)
    else $error("read data late or missing");
  a_read_mask: assert property (s_rd |-> data_mask == 4'h0)
    else $error("byte mask not low on read");
  a_one_select: assert property ($onehot0(dyn_on) && $onehot0(st_on) && !(|dyn_on && st_any))
    else $error("more than one select active");
  a_lanes_on: assert property (byte_lane_policy_bit && !oe_n |-> byte_lane_n == 4'h0)
    else $error("strobes not low on read");
  a_lanes_off: assert property (!byte_lane_policy_bit && !oe_n |-> byte_lane_n == 4'hf)
    else $error("strobes not high on read");
  a_strobe_write: assert property (!byte_lane_policy_bit && st_any |-> we_n)
    else $error("write enable moved with strobe policy");
  a_write_lead: assert property ($fell(we_n) && st_any |-> $past(st_any))
    else $error("select not ahead of write enable");
  a_write_tail: assert property ($rose(we_n) && st_any |-> ##1 !st_any)
    else $error("select not released after write enable");
endmodule
bind emcs_sequencer emcs_sequencer_chk u_chk (.clock(clock), .rst(rst), .clk_en(clk_en),
  .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n), .rsp_valid(rsp_valid),
  .byte_lane_policy_bit(byte_lane_policy_bit), .data_mask(data_mask),
  .byte_lane_n(byte_lane_n), .dynamic_select_low(dynamic_select_low),
  .static_select_low(static_select_low), .select_polarity_field(select_polarity_field));
`default_nettype wire

// ---- emcs_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define EMCS_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module emcs_sequencer_tb;
  logic        clock = 1'b0, rst = 1'b1, ce = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic        req_sdram = 1'b0, req_page = 1'b0, pb = 1'b1, b32 = 1'b1;
  logic [1:0]  req_size = 2'h2, req_bank = 2'h0, sw = 2'h2;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, seed = 32'h0001466b;
  logic [3:0]  rw = 4'h1, oed = 4'h1, pw = 4'h1, ww = 4'h0, wed = 4'h0, pol = 4'h0;
  wire logic        req_ready, rsp_valid, rsp_last, clk_en, ras_n, cas_n, we_n, oe_n, data_oe;
  wire logic [31:0] rsp_data, data_out, data_in;
  wire logic [3:0]  dsel, ssel, data_mask, byte_lane_n;
  wire logic [23:0] mem_addr;
  int          n_fail = 0, n_checks = 0, cyc = 0;
  logic [32:0] exp_q[$];
  int          exp_t[$];
  logic [31:0] exp_w = 32'h0;
  logic [3:0]  exp_l = 4'h0;
  always #10 clock = ~clock;
  emcs_sequencer uut (.clock(clock), .rst(rst), .ce(ce), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_sdram(req_sdram), .req_page(req_page),
    .req_size(req_size), .req_bank(req_bank), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last), .rsp_data(rsp_data), .read_wait_field(rw),
    .output_enable_delay_field(oed), .page_wait_field(pw), .write_wait_field(ww),
    .write_enable_delay_field(wed), .byte_lane_policy_bit(pb), .select_polarity_field(pol),
    .static_width(sw), .sdram_bus32(b32), .clk_en(clk_en), .dynamic_select_low(dsel),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .data_mask(data_mask),
    .static_select_low(ssel), .oe_n(oe_n), .byte_lane_n(byte_lane_n), .mem_addr(mem_addr),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  emcs_mem_model mem (.clock(clock), .dynamic_select_low(dsel), .static_select_low(ssel),
    .select_polarity_field(pol), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .oe_n(oe_n),
    .mem_addr(mem_addr), .data_in(data_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // Expected beats are queued at the edge that takes the request
  task automatic xfer(input logic w, sd, pg, input logic [1:0] bk, input logic [31:0] a);
    int          t, k, n;
    logic [23:0] u;
    begin
      req_valid <= 1'b1;
      req_write <= w;
      req_sdram <= sd;
      req_page  <= pg;
      req_bank  <= bk;
      req_addr  <= a;
      req_wdata <= ~a;
      req_size  <= sd ? 2'h2 : sw;
      @(posedge clock);
      while (!req_ready) @(posedge clock);
      req_valid <= 1'b0;
      exp_w = ~a;
      exp_l = (sw == 2'h2) ? 4'hf : (sw == 2'h1) ? (a[1] ? 4'hc : 4'h3) : 4'h1 << a[1:0];
      if (!w && sd) begin
        u = 24'(a >> (b32 ? 2 : 1));
        exp_q.push_back({1'b1, 8'h5a, 15'h0, u[8:0]});
        exp_t.push_back(cyc + 10);
      end else if (!w) begin
        n = pg ? (16 >> sw) : 1;
        u = 24'(a >> sw);
        if (pg)
          u = u & ~24'(n - 1);
        t = cyc + 3;
        for (k = 0; k < n; k++) begin
          t += (k % 4 == 0) ? ((rw == 4'h0) ? 2 : rw + 1) : pw + 1;
          exp_q.push_back({k == n - 1, 8'ha5, u + 24'(k)});
          exp_t.push_back(t);
        end
      end
      @(posedge clock);
      while (!req_ready) @(posedge clock);
    end
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      end_of_test();
    end
  end
  always @(posedge clock) begin
    if (!rst && rsp_valid) begin
      if (exp_q.size() == 0)
        `EMCS_CHK("rsp_count", 1'b0, 1'b1)
      else begin
        `EMCS_CHK("rsp_data", exp_q[0][31:0], rsp_data)
        `EMCS_CHK("rsp_last", exp_q[0][32], rsp_last)
        `EMCS_CHK("rsp_time", exp_t[0], cyc)
        void'(exp_q.pop_front());
        void'(exp_t.pop_front());
      end
    end
  end
  // Write data and strobes while the data bus is driven
  always @(posedge clock) begin
    if (!rst && data_oe) begin
      `EMCS_CHK("write_data", exp_w, data_out)
      if (byte_lane_n != 4'hf)
        `EMCS_CHK("write_lanes", ~exp_l, byte_lane_n)
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    `EMCS_CHK("ready", 1'b1, req_ready)
    `EMCS_CHK("clk_en", 1'b0, clk_en)
    `EMCS_CHK("static_select", ~pol, ssel)
    `EMCS_CHK("dynamic_select", ~pol, dsel)
    xfer(1'b0, 1'b0, 1'b0, 2'h1, 32'h0000_0124);
    for (int w = 0; w < 3; w++) begin
      sw <= 2'(w);
      pb <= w[0];
      rw <= 4'h2;
      @(posedge clock);
      xfer(1'b0, 1'b0, 1'b1, 2'(w), 32'h0000_3457 + 32'(w));
    end
    for (int i = 0; i < 4; i++) begin
      b32 <= i[0];
      @(posedge clock);
      xfer(i[1], 1'b1, 1'b0, 2'(i), 32'h0012_3450 + 32'(i));
    end
    repeat (40) begin
      seed = lfsr(seed);
      {rw, oed, pw, ww, wed, pol} <= seed[23:0];
      pb  <= seed[24];
      b32 <= seed[25];
      sw  <= (seed[27:26] == 2'h3) ? 2'h2 : seed[27:26];
      @(posedge clock);
      seed = lfsr(seed);
      xfer(seed[0], seed[1], seed[2], seed[4:3], lfsr(seed));
    end
    repeat (12) @(posedge clock);
    `EMCS_CHK("beats_left", 0, exp_q.size())
    end_of_test();
  end
endmodule
`undef EMCS_CHK
`default_nettype wire
